// ### rtl/cwd_pkg.sv
// Shared constants, register layout and types for the counter array watchdog.
package cwd_pkg;
    // ***************************************************************
    // Register addresses on the special function register bus
    // ***************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_MODE = 8'hD9;
    localparam logic [7:0] ADDR_CNT_LOW = 8'hE9;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'hF9;
    localparam logic [7:0] ADDR_WD_OFFSET = 8'hEE;
    localparam logic [7:0] ADDR_WD_RELOAD = 8'hFE;

    // ***************************************************************
    // Field positions and reset values
    // ***************************************************************
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_MATCH4_BIT = 4;
    localparam int MODE_ENABLE_BIT = 6;
    localparam int MODE_LOCK_BIT = 5;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // ***************************************************************
    // Prescaler terminal counts
    // ***************************************************************
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // Counter clock sources.
    typedef enum logic [2:0] {
        CLK_DIV12 = 3'b000,
        CLK_DIV4 = 3'b001,
        CLK_TIMER0 = 3'b010,
        CLK_EXT_PIN = 3'b011,
        CLK_SYS = 3'b100,
        CLK_EXTOSC_DIV8 = 3'b101
    } cwd_clksel_type;

    // Mode register layout, most significant bit first.
    typedef struct packed {
        logic idleSuspend;
        logic wdEnable;
        logic wdLock;
        logic reserved;
        cwd_clksel_type clkSel;
        logic ovfIntEn;
    } cwd_mode_type;
endpackage

// ### rtl/cwd_prescaler.sv
// Counter clock prescaler producing one tick per selected counter clock.
`timescale 1ns/1ps
`default_nettype none
module cwd_prescaler (
    input wire logic clock,
    input wire logic rst_n,
    input wire cwd_pkg::cwd_clksel_type clkSel,
    input wire logic timer0Overflow,
    input wire logic extPin,
    input wire logic extOscTick,
    output logic tick
);
    import cwd_pkg::*;

    logic [3:0] div12;
    logic [1:0] div4;
    logic [2:0] div8;
    logic pinMeta;
    logic pinSync;
    logic pinLast;
    logic next_tick;
    wire pinFall = pinLast && !pinSync;

    // The pin is synchronised twice before the edge detector sees it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end else begin
            pinMeta <= extPin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    // Dividers ignore the select, so switching source is glitch free; div8 advances only on oscillator ticks.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div12 <= 4'h0;
            div4 <= 2'h0;
            div8 <= 3'h0;
        end else begin
            div12 <= (div12 == DIV12_LAST) ? 4'h0 : div12 + 4'h1;
            div4 <= div4 + 2'h1;
            if (extOscTick) begin
                div8 <= div8 + 3'h1;
            end
        end
    end

    // Source selection; unused codes give no tick at all.
    always_comb begin
        case (clkSel)
            CLK_DIV12: next_tick = (div12 == DIV12_LAST);
            CLK_DIV4: next_tick = (div4 == DIV4_LAST);
            CLK_TIMER0: next_tick = timer0Overflow;
            CLK_EXT_PIN: next_tick = pinFall;
            CLK_SYS: next_tick = 1'b1;
            CLK_EXTOSC_DIV8: next_tick = extOscTick && (div8 == DIV8_LAST);
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ### rtl/cwd_watchdog.sv
// Counter array with its compare module four working as the system watchdog.
// ***************************************************************
// Behaviour
// - With the idle suspend bit set, counting stops while the processor idles.
// - While enabled, the clock select and idle suspend fields ignore writes.
// - The watchdog counts as enabled when either the enable or the lock bit is set.
// - Once locked, the watchdog cannot be disabled until the next reset.
// - Without the lock, clearing the enable bit disables the watchdog.
// - Reset leaves the watchdog enabled with the clock at system clock divided by twelve.
// - Reset clears the counter bytes and the reload byte, giving a 256 tick timeout.
// - A watchdog reset fires when the low byte wraps while the reload byte equals the high byte.
// - Any write to the reload register loads it with the high byte plus the offset.
// - Writing one to the module four flag while enabled forces an immediate watchdog reset.
// - While enabled, the counter is forced to run and counter byte writes are blocked.
// ***************************************************************
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    output logic [7:0] sfrRdData,
    input wire logic cpuIdle,
    input wire logic timer0Overflow,
    input wire logic extPin,
    input wire logic extOscTick,
    output logic watchdogReset,
    output logic watchdogEnabled
);
    import cwd_pkg::*;

    cwd_mode_type mode;
    cwd_mode_type next_mode;
    logic [7:0] cntLow;
    logic [7:0] cntHigh;
    logic [7:0] wdOffset;
    logic [7:0] wdReload;
    logic ovfFlag;
    logic runBit;
    logic match4Flag;
    logic tick;

    // ***************************************************************
    // Address decode and event terms
    // ***************************************************************
    wire cwd_mode_type wrMode = cwd_mode_type'(sfrWrData);
    wire wrCtrl = sfrWrite && (sfrAddr == ADDR_CONTROL);
    wire wrModeReg = sfrWrite && (sfrAddr == ADDR_MODE);
    wire wrLow = sfrWrite && (sfrAddr == ADDR_CNT_LOW);
    wire wrHigh = sfrWrite && (sfrAddr == ADDR_CNT_HIGH);
    wire wrOffset = sfrWrite && (sfrAddr == ADDR_WD_OFFSET);
    wire wrReload = sfrWrite && (sfrAddr == ADDR_WD_RELOAD);
    wire wdEnabled = mode.wdEnable || mode.wdLock;
    wire suspended = mode.idleSuspend && cpuIdle;
    wire counterRuns = (runBit || wdEnabled) && !suspended;
    wire count = tick && counterRuns;
    wire lowWrap = count && (cntLow == BYTE_ALL_ONES);
    wire highWrap = lowWrap && (cntHigh == BYTE_ALL_ONES);
    wire wdTimeout = wdEnabled && lowWrap && (wdReload == cntHigh);
    wire forceReset = wdEnabled && wrCtrl && sfrWrData[CTRL_MATCH4_BIT];
    wire [7:0] reloadTarget = cntHigh + wdOffset;
    wire [7:0] ctrlRead = {ovfFlag, runBit, 1'b0, match4Flag, 4'h0};

    assign watchdogEnabled = wdEnabled;

    // Counter clock source follows the frozen select field.
    cwd_prescaler prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .clkSel(mode.clkSel),
        .timer0Overflow(timer0Overflow),
        .extPin(extPin),
        .extOscTick(extOscTick),
        .tick(tick)
    );

    // Mode update: frozen fields keep their value while enabled, and the lock is sticky.
    always_comb begin
        next_mode = mode;
        if (wrModeReg) begin
            if (!wdEnabled) begin
                next_mode.idleSuspend = wrMode.idleSuspend;
                next_mode.clkSel = wrMode.clkSel;
            end
            next_mode.wdEnable = wrMode.wdEnable;
            next_mode.wdLock = mode.wdLock || wrMode.wdLock;
            next_mode.ovfIntEn = wrMode.ovfIntEn;
            next_mode.reserved = 1'b0;
        end
    end

    // Mode register comes out of reset with the watchdog armed.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode <= cwd_mode_type'(MODE_RESET);
        end else begin
            mode <= next_mode;
        end
    end

    // ***************************************************************
    // Counter bytes
    // ***************************************************************
    // Software writes lose to nothing but the watchdog, which blocks them outright.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cntLow <= BYTE_ZERO;
            cntHigh <= BYTE_ZERO;
        end else begin
            if (wrLow && !wdEnabled) begin
                cntLow <= sfrWrData;
            end else if (count) begin
                cntLow <= cntLow + BYTE_ONE;
            end
            if (wrHigh && !wdEnabled) begin
                cntHigh <= sfrWrData;
            end else if (lowWrap) begin
                cntHigh <= cntHigh + BYTE_ONE;
            end
        end
    end

    // Control flags; a wrap in the same cycle as a clear keeps the flag set.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovfFlag <= 1'b0;
            runBit <= 1'b0;
            match4Flag <= 1'b0;
        end else begin
            if (highWrap) begin
                ovfFlag <= 1'b1;
            end else if (wrCtrl) begin
                ovfFlag <= sfrWrData[CTRL_OVF_BIT];
            end
            if (wrCtrl) begin
                runBit <= sfrWrData[CTRL_RUN_BIT];
                match4Flag <= sfrWrData[CTRL_MATCH4_BIT] && !wdEnabled;
            end
        end
    end

    // Offset and reload bytes; the written reload value itself is discarded.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wdOffset <= BYTE_ZERO;
            wdReload <= BYTE_ZERO;
        end else begin
            if (wrOffset) begin
                wdOffset <= sfrWrData;
            end
            if (wrReload) begin
                wdReload <= reloadTarget;
            end
        end
    end

    // Reset request is one registered pulse, so the system reset logic sees a clean edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdogReset <= 1'b0;
        end else begin
            watchdogReset <= wdTimeout || forceReset;
        end
    end

    // ***************************************************************
    // Read path
    // ***************************************************************
    // Unmapped addresses read as zero; read data is valid the cycle after the strobe.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdData <= BYTE_ZERO;
        end else if (sfrRead) begin
            case (sfrAddr)
                ADDR_CONTROL: sfrRdData <= ctrlRead;
                ADDR_MODE: sfrRdData <= mode;
                ADDR_CNT_LOW: sfrRdData <= cntLow;
                ADDR_CNT_HIGH: sfrRdData <= cntHigh;
                ADDR_WD_OFFSET: sfrRdData <= wdOffset;
                ADDR_WD_RELOAD: sfrRdData <= wdReload;
                default: sfrRdData <= BYTE_ZERO;
            endcase
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_timeout_fires: assert property (wdEnabled && lowWrap && wdReload == cntHigh |=> watchdogReset)
        else $error("timeout did not raise watchdog reset");
    a_reset_cause: assert property (watchdogReset |-> $past(wdTimeout) || $past(forceReset))
        else $error("watchdog reset without cause");
    a_force_reset: assert property (wdEnabled && wrCtrl && sfrWrData[CTRL_MATCH4_BIT] |=> watchdogReset)
        else $error("forced reset missing");
    a_lock_sticky: assert property (mode.wdLock |=> mode.wdLock && watchdogEnabled)
        else $error("lock released or watchdog disabled while locked");
    a_clksel_frozen: assert property (wdEnabled && wrModeReg |=> mode.clkSel == $past(mode.clkSel))
        else $error("clock select changed while enabled");
    a_idle_frozen: assert property (wdEnabled |=> mode.idleSuspend == $past(mode.idleSuspend))
        else $error("idle suspend changed while enabled");
    a_idle_stops: assert property (wdEnabled && suspended && !wrLow |=> cntLow == $past(cntLow))
        else $error("counter moved while suspended");
    a_low_blocked: assert property (wdEnabled && wrLow && !count |=> cntLow == $past(cntLow))
        else $error("counter low byte written while enabled");
    a_reload_load: assert property (wrReload |=> wdReload == $past(reloadTarget))
        else $error("reload value wrong");
    a_disable_ok: assert property (!mode.wdLock && wrModeReg && !sfrWrData[MODE_ENABLE_BIT]
        && !sfrWrData[MODE_LOCK_BIT] |=> !watchdogEnabled)
        else $error("watchdog not disabled");
    a_ovf_sets: assert property (highWrap |=> ovfFlag ##1 ovfFlag || $past(wrCtrl))
        else $error("overflow flag not held");

    c_timeout: cover property (wdTimeout ##1 watchdogReset);
    c_forced: cover property (forceReset);
    c_locked: cover property (!mode.wdLock ##1 mode.wdLock);
    c_reload: cover property (wrReload && wdEnabled);
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the counter array watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cwd_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrRdData;
    logic cpuIdle = 1'b0;
    logic timer0Overflow = 1'b0;
    logic extPin = 1'b1;
    logic extOscTick = 1'b0;
    logic watchdogReset;
    logic watchdogEnabled;
    logic readTaken = 1'b0;
    logic [7:0] expQ[$];
    logic [7:0] expVal;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    int n;
    logic [7:0] off;
    // The whole run needs about 5500 cycles; the ceiling leaves ample margin.
    localparam int CYCLE_LIMIT = 30000;

    cwd_watchdog DUT (.clock(clock), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData), .cpuIdle(cpuIdle),
        .timer0Overflow(timer0Overflow), .extPin(extPin), .extOscTick(extOscTick),
        .watchdogReset(watchdogReset), .watchdogEnabled(watchdogEnabled));

    // ***************************************************************
    // Clock, cycle count and hang guard
    // ***************************************************************
    initial begin
        forever #12.5 clock = ~clock;
    end

    // A hung wait must still reach the closing report, so the guard counts as a mismatch.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == CYCLE_LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    // ***************************************************************
    // Comparison and closing tasks
    // ***************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data is registered, so it is judged half a cycle after the edge that took the read.
    always @(posedge clock) readTaken <= sfrRead;
    always @(negedge clock) begin
        if (readTaken) begin
            expVal = expQ.pop_front();
            check(sfrRdData, expVal);
        end
    end

    // ***************************************************************
    // Bus and reset tasks
    // ***************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #2 sfrWrite = 1'b1;
        sfrAddr = a;
        sfrWrData = d;
        @(posedge clock);
        #2 sfrWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        #2 sfrRead = 1'b1;
        sfrAddr = a;
        expQ.push_back(exp);
        @(posedge clock);
        #2 sfrRead = 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clock);
        #2 rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #2 rst_n = 1'b1;
    endtask

    // Returns the cycle index of the first reset pulse, or -1 if none came within the limit.
    task automatic wait_reset(input int limit, output int idx);
        idx = -1;
        for (int i = 0; i < limit; i++) begin
            @(negedge clock);
            if (watchdogReset === 1'b1) begin
                idx = i;
                break;
            end
        end
    endtask

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        void'($urandom(57));
        off = 8'(1 + $urandom % 3);
        repeat (2) @(posedge clock);
        #2 rst_n = 1'b1;
        // Reset values and the default 256-tick timeout at sysclk / 12.
        t0 = cyc;
        check(8'(watchdogEnabled), 8'h01);
        rd(ADDR_MODE, MODE_RESET);
        rd(ADDR_CONTROL, 8'h00);
        rd(ADDR_WD_OFFSET, 8'h00);
        rd(8'h77, 8'h00);
        wait_reset(4000, n);
        check_range(cyc - t0, 256 * 12 - 12, 256 * 12 + 30);
        // Software-forced reset through the module four flag.
        do_reset();
        wr(ADDR_CONTROL, 8'h10);
        wait_reset(3, n);
        check_range(n, 0, 1);
        rd(ADDR_CONTROL, 8'h00);
        // Configure with the watchdog off, then enable and reload.
        wr(ADDR_MODE, 8'h00);
        check(8'(watchdogEnabled), 8'h00);
        wr(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_CNT_HIGH, 8'h10);
        wr(ADDR_WD_OFFSET, off);
        wr(ADDR_MODE, 8'h08);
        rd(ADDR_MODE, 8'h08);
        rd(ADDR_CNT_HIGH, 8'h10);
        wr(ADDR_MODE, 8'h48);
        t0 = cyc;
        wr(ADDR_WD_RELOAD, 8'($urandom));
        rd(ADDR_WD_RELOAD, 8'h10 + off);
        wr(ADDR_MODE, 8'hC0);
        rd(ADDR_MODE, 8'h48);
        wr(ADDR_CNT_HIGH, 8'hA5);
        rd(ADDR_CNT_HIGH, 8'h10);
        wait_reset(2000, n);
        check_range(cyc - t0, (off + 1) * 256 - 20, (off + 1) * 256 + 16);
        // The lock keeps the watchdog on and survives a cleared enable bit.
        do_reset();
        wr(ADDR_MODE, 8'h60);
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_MODE, 8'h20);
        check(8'(watchdogEnabled), 8'h01);
        do_reset();
        rd(ADDR_MODE, MODE_RESET);
        // Idle suspend holds the count while the processor idles.
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_MODE, 8'h88);
        wr(ADDR_MODE, 8'hC8);
        wr(ADDR_WD_RELOAD, 8'h00);
        @(posedge clock);
        #2 cpuIdle = 1'b1;
        wait_reset(700, n);
        check_range(n, -1, -1);
        @(posedge clock);
        #2 cpuIdle = 1'b0;
        wait_reset(300, n);
        check_range(n, 0, 299);
        // Overflow flag sets on the 16-bit wrap and stays until cleared.
        do_reset();
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_CNT_LOW, 8'hF0);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h40);
        repeat (60) @(posedge clock);
        rd(ADDR_CONTROL, 8'hC0);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        // Event clocks: one count per pin fall, per timer 0 overflow and per eighth oscillator tick.
        // The pin is held low and high for several cycles so the two-stage synchroniser sees each level.
        wr(ADDR_MODE, 8'h06);
        wr(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h40);
        n = 3 + $urandom % 5;
        repeat (n) begin
            @(posedge clock);
            #2 extPin = 1'b0;
            repeat (4) @(posedge clock);
            #2 extPin = 1'b1;
            repeat (4) @(posedge clock);
        end
        rd(ADDR_CNT_LOW, 8'(n));
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_CNT_LOW, 8'h00);
        n = 3 + $urandom % 5;
        repeat (n) begin
            @(posedge clock);
            #2 timer0Overflow = 1'b1;
            @(posedge clock);
            #2 timer0Overflow = 1'b0;
        end
        rd(ADDR_CNT_LOW, 8'(n));
        // The oscillator divider has seen no tick since the last reset, so sixteen ticks give two counts.
        wr(ADDR_MODE, 8'h0A);
        wr(ADDR_CNT_LOW, 8'h00);
        repeat (16) begin
            @(posedge clock);
            #2 extOscTick = 1'b1;
            @(posedge clock);
            #2 extOscTick = 1'b0;
        end
        rd(ADDR_CNT_LOW, 8'h02);
        repeat (3) @(posedge clock);
        wrap_up();
    end
endmodule
`default_nettype wire
